// >>> pss_start_sel.sv
`timescale 1ns/1ps
// Contract
// - start input rising launches the entry shown on the select lines
// - select lines decode as binary, lowest line bit 0, entries 0 to 15
// - ready drops once a move begins; host releases start after that
// - ready returns high when the move completes
// - a direct-start input rising launches its mapped entry
// - each direct-start input has a 0-15 map, defaults 0 to 5
// - sequence step launches the entry after the previously executed one
// - next entry with sequential flag off wraps to the start point
// - select-start or direct-start sets the new sequence start point
// - with no start point set, first step runs entry 0
// - torque limit entry always follows the select lines
// - clear events reset start point to 0 and present number to -1
// - sixteen one-bit sequential flags, default disabled
module pss_start_sel (
  input wire logic clk_i,                                // 250 MHz clock
  input wire logic rst_i,                                // async reset, active high
  input wire logic psel,                                 // apb select
  input wire logic penable,                              // apb access phase
  input wire logic pwrite,                               // apb direction
  input wire logic [7:0] paddr,                          // apb byte address
  input wire logic [31:0] pwdata,                        // apb write data
  input wire logic [3:0] pstrb,                          // apb byte strobes
  output logic [31:0] prdata,                            // apb read data
  output logic pready,                                   // apb ready
  output logic pslverr,                                  // apb error
  input wire logic start_i,                              // select-mode start
  input wire logic [pss_pkg::ENTRY_W-1:0] data_number_select_lines_i, // entry select
  input wire logic [pss_pkg::NUM_DIRECT-1:0] direct_start_inputs_i,   // direct starts
  input wire logic sequence_step_input_i,                // sequence step
  input wire logic move_done_i,                          // profile finished, pulse
  input wire logic non_positioning_op_i,                 // other operation running
  input wire logic alarm_reset_i,                        // alarm reset event
  input wire logic input_a_i,                            // input_a input
  input wire logic excitation_off_i,                     // excitation-off command
  input wire logic position_preset_i,                    // position preset event
  output logic ready_o,                                  // ready for a start
  output logic move_start_o,                             // one-cycle launch pulse
  output logic [pss_pkg::ENTRY_W-1:0] move_data_no_o,    // entry being run
  output logic [pss_pkg::ENTRY_W-1:0] torque_data_no_o,  // entry for torque limit
  output logic [4:0] present_data_no_o,                  // present number, 1F = -1
  output logic [pss_pkg::ENTRY_W-1:0] seq_start_point_o  // sequence start point
);
  import pss_pkg::*;

  pss_cfg_if cfg ();
  pss_state_t state_q;
  logic rise_start;
  logic [NUM_DIRECT-1:0] rise_direct;
  logic rise_seq;
  logic clear_evt;
  logic launch;
  logic [ENTRY_W-1:0] launch_no;
  logic [1:0] launch_method;
  logic [ENTRY_W-1:0] direct_no;
  logic [ENTRY_W-1:0] seq_next;
  logic [ENTRY_W-1:0] seq_cand;
  logic [ENTRY_W-1:0] start_q;
  logic [4:0] present_q;
  logic [ENTRY_W-1:0] run_q;
  logic [1:0] method_q;
  logic [ENTRY_W-1:0] torque_q;
  logic move_start_q;
  logic [31:0] prdata_q;
  logic addr_ok;
  logic setup;
  logic access;

  pss_edge #(
    .W(1)
  ) u_edge_start (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(start_i),
    .rise_o(rise_start)
  );

  pss_edge #(
    .W(NUM_DIRECT)
  ) u_edge_direct (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(direct_start_inputs_i),
    .rise_o(rise_direct)
  );

  pss_edge #(
    .W(1)
  ) u_edge_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(sequence_step_input_i),
    .rise_o(rise_seq)
  );

  pss_cfg_regs u_cfg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg(cfg.store)
  );

  // any of these events forgets the sequence position
  assign clear_evt = non_positioning_op_i | alarm_reset_i | input_a_i
                   | excitation_off_i | position_preset_i;

  // lowest-numbered direct input wins if several rise together
  always_comb
  begin
    direct_no = '0;
    for (int i = NUM_DIRECT - 1; i >= 0; i--)
    begin
      if (rise_direct[i])
      begin
        direct_no = cfg.direct_map[i*ENTRY_W +: ENTRY_W];
      end
    end
  end

  // next sequence entry; entry 15 never rolls into 0, it returns to the start point
  always_comb
  begin
    seq_cand = present_q[ENTRY_W-1:0] + 4'h1;
    if (present_q == PRESENT_NONE)
    begin
      seq_next = start_q;
    end
    else if (present_q[ENTRY_W-1:0] == LAST_ENTRY || !cfg.seq_flags[seq_cand])
    begin
      seq_next = start_q;
    end
    else
    begin
      seq_next = seq_cand;
    end
  end

  // pick the launch source; a clear event in the same cycle blocks it
  always_comb
  begin
    launch = 1'b0;
    launch_no = '0;
    launch_method = METHOD_NONE;
    if (state_q == PSS_IDLE && !clear_evt)
    begin
      if (rise_start)
      begin
        launch = 1'b1;
        launch_no = data_number_select_lines_i;
        launch_method = METHOD_SELECT;
      end
      else if (|rise_direct)
      begin
        launch = 1'b1;
        launch_no = direct_no;
        launch_method = METHOD_DIRECT;
      end
      else if (rise_seq)
      begin
        launch = 1'b1;
        launch_no = seq_next;
        launch_method = METHOD_SEQ;
      end
    end
  end

  // move state: busy from launch until the profile reports completion
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= PSS_IDLE;
    end
    else
    begin
      unique case (state_q)
        PSS_IDLE:
        begin
          if (launch)
          begin
            state_q <= PSS_BUSY;
          end
        end
        PSS_BUSY:
        begin
          if (move_done_i)
          begin
            state_q <= PSS_IDLE;
          end
        end
      endcase
    end
  end

  // sequence start point and present entry number
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_q <= START_POINT_RST;
      present_q <= PRESENT_NONE;
    end
    else if (clear_evt)
    begin
      start_q <= START_POINT_RST;
      present_q <= PRESENT_NONE;
    end
    else if (launch)
    begin
      present_q <= {1'b0, launch_no};
      if (launch_method != METHOD_SEQ)
      begin
        start_q <= launch_no;
      end
    end
  end

  // launch pulse and the entry handed to the profile generator
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      move_start_q <= 1'b0;
      run_q <= '0;
      method_q <= METHOD_NONE;
    end
    else
    begin
      move_start_q <= launch;
      if (launch)
      begin
        run_q <= launch_no;
        method_q <= launch_method;
      end
    end
  end

  // torque entry tracks the select lines for every start method, even mid-move
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      torque_q <= '0;
    end
    else
    begin
      torque_q <= data_number_select_lines_i;
    end
  end

  assign ready_o = (state_q == PSS_IDLE);
  assign move_start_o = move_start_q;
  assign move_data_no_o = run_q;
  assign torque_data_no_o = torque_q;
  assign present_data_no_o = present_q;
  assign seq_start_point_o = start_q;

  // apb decode: zero wait states, read data captured in the setup cycle
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign addr_ok = (paddr == OFS_DIRECT_MAP) || (paddr == OFS_SEQ_FLAGS)
                 || (paddr == OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;

  // table writes land on the access edge; status is read-only
  assign cfg.wr_en = access & pwrite & ((paddr == OFS_DIRECT_MAP) || (paddr == OFS_SEQ_FLAGS));
  assign cfg.wr_flags = (paddr == OFS_SEQ_FLAGS);
  assign cfg.wr_data = pwdata;
  assign cfg.wr_strb = pstrb;

  // read mux registered so prdata comes from a flop; unmapped reads zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (setup)
    begin
      prdata_q <= 32'h00000000;
      if (!pwrite)
      begin
        if (paddr == OFS_DIRECT_MAP)
        begin
          prdata_q <= {8'h00, cfg.direct_map};
        end
        else if (paddr == OFS_SEQ_FLAGS)
        begin
          prdata_q <= {16'h0000, cfg.seq_flags};
        end
        else if (paddr == OFS_STATUS)
        begin
          prdata_q[STAT_READY_BIT] <= ready_o;
          prdata_q[STAT_PRESENT_LSB +: 5] <= present_q;
          prdata_q[STAT_START_LSB +: ENTRY_W] <= start_q;
          prdata_q[STAT_RUN_LSB +: ENTRY_W] <= run_q;
          prdata_q[STAT_METHOD_LSB +: 2] <= method_q;
        end
      end
    end
  end

  assign prdata = prdata_q;

endmodule : pss_start_sel

// >>> pss_pkg.sv
package pss_pkg;

  // table sizes
  localparam int unsigned NUM_ENTRIES = 16;
  localparam int unsigned ENTRY_W = 4;
  localparam int unsigned NUM_DIRECT = 6;

  // register byte offsets
  localparam logic [7:0] OFS_DIRECT_MAP = 8'h00;
  localparam logic [7:0] OFS_SEQ_FLAGS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // values after reset, and the last entry number
  localparam logic [23:0] DIRECT_MAP_RST = 24'h543210;
  localparam logic [15:0] SEQ_FLAGS_RST = 16'h0000;
  localparam logic [3:0] START_POINT_RST = 4'h0;
  localparam logic [4:0] PRESENT_NONE = 5'h1F;
  localparam logic [3:0] LAST_ENTRY = 4'hF;

  // status field positions
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_PRESENT_LSB = 8;
  localparam int unsigned STAT_START_LSB = 16;
  localparam int unsigned STAT_RUN_LSB = 24;
  localparam int unsigned STAT_METHOD_LSB = 28;

  // how the last move was launched
  localparam logic [1:0] METHOD_NONE = 2'h0;
  localparam logic [1:0] METHOD_SELECT = 2'h1;
  localparam logic [1:0] METHOD_DIRECT = 2'h2;
  localparam logic [1:0] METHOD_SEQ = 2'h3;

  typedef enum logic [1:0] {
    PSS_IDLE = 2'b01,
    PSS_BUSY = 2'b10
  } pss_state_t;

endpackage : pss_pkg

// >>> pss_cfg_if.sv
`timescale 1ns/1ps
// configuration path between the bus side and the table storage
interface pss_cfg_if;
  logic wr_en;
  logic wr_flags;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [23:0] direct_map;
  logic [15:0] seq_flags;

  modport core (
    output wr_en,
    output wr_flags,
    output wr_data,
    output wr_strb,
    input direct_map,
    input seq_flags
  );

  modport store (
    input wr_en,
    input wr_flags,
    input wr_data,
    input wr_strb,
    output direct_map,
    output seq_flags
  );
endinterface : pss_cfg_if

// >>> pss_edge.sv
`timescale 1ns/1ps
// off-to-on detector for a group of discrete inputs
module pss_edge #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,            // system clock
  input wire logic rst_i,            // async reset, active high
  input wire logic [W-1:0] level_i,  // input levels
  output logic [W-1:0] rise_o        // one-cycle pulse per rising edge
);

  logic [W-1:0] prev_q;

  // previous level starts high so an input already on at reset release
  // does not launch a move; it must go off and on again
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_q <= '1;
    end
    else
    begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;

endmodule : pss_edge

// >>> pss_cfg_regs.sv
`timescale 1ns/1ps
// storage for the direct-start map and the per-entry sequential flags
module pss_cfg_regs (
  input wire logic clk_i,      // system clock
  input wire logic rst_i,      // async reset, active high
  pss_cfg_if.store cfg         // write port and table contents
);
  import pss_pkg::*;

  // direct-start map, four bits per input, byte-lane writes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg.direct_map <= DIRECT_MAP_RST;
    end
    else if (cfg.wr_en && !cfg.wr_flags)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (cfg.wr_strb[b])
        begin
          cfg.direct_map[b*8 +: 8] <= cfg.wr_data[b*8 +: 8];
        end
      end
    end
  end

  // sequential flags, one bit per entry, all disabled after reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg.seq_flags <= SEQ_FLAGS_RST;
    end
    else if (cfg.wr_en && cfg.wr_flags)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (cfg.wr_strb[b])
        begin
          cfg.seq_flags[b*8 +: 8] <= cfg.wr_data[b*8 +: 8];
        end
      end
    end
  end

endmodule : pss_cfg_regs

// >>> pss_start_sel_asserts.sv
`timescale 1ns/1ps
// port-level checks on the start selector
module pss_start_sel_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic start_i, // start
  input wire logic [pss_pkg::ENTRY_W-1:0] data_number_select_lines_i, // select
  input wire logic [pss_pkg::NUM_DIRECT-1:0] direct_start_inputs_i, // direct
  input wire logic move_done_i, // done
  input wire logic non_positioning_op_i, // clear
  input wire logic alarm_reset_i, // clear
  input wire logic input_a_i, // clear
  input wire logic excitation_off_i, // clear
  input wire logic position_preset_i, // clear
  input wire logic ready_o, // ready
  input wire logic move_start_o, // launch
  input wire logic [pss_pkg::ENTRY_W-1:0] move_data_no_o, // run entry
  input wire logic [pss_pkg::ENTRY_W-1:0] torque_data_no_o, // torque entry
  input wire logic [4:0] present_data_no_o, // present
  input wire logic [pss_pkg::ENTRY_W-1:0] seq_start_point_o // start point
);
  import pss_pkg::*;
  logic clr;
  // any clear event; it beats a launch in the same cycle
  assign clr = non_positioning_op_i | alarm_reset_i | input_a_i | excitation_off_i
    | position_preset_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // idle and uncleared; the edge detectors need one cycle after reset to see a rise
  sequence open_s;
    ready_o && !clr && !$past(rst_i);
  endsequence
  sel_launch_a: assert property (
    open_s ##0 $rose(start_i) |=> move_start_o
    && move_data_no_o == $past(data_number_select_lines_i)) else $error("select launch");
  direct_launch_a: assert property (
    open_s ##0 (direct_start_inputs_i & ~$past(direct_start_inputs_i)) != '0
    |=> move_start_o) else $error("direct launch");
  busy_ignore_a: assert property (
    !ready_o || clr |=> !move_start_o) else $error("launch while busy");
  ready_drop_a: assert property (
    move_start_o |-> !ready_o) else $error("ready stayed high");
  ready_back_a: assert property (
    !ready_o && move_done_i |=> ready_o) else $error("ready not back");
  present_track_a: assert property (
    move_start_o |-> present_data_no_o == {1'b0, move_data_no_o}) else $error("present");
  torque_follow_a: assert property (
    $changed(data_number_select_lines_i)
    |=> torque_data_no_o == $past(data_number_select_lines_i)) else $error("torque");
  clear_state_a: assert property (
    clr |=> seq_start_point_o == START_POINT_RST && present_data_no_o == PRESENT_NONE)
    else $error("clear");
endmodule : pss_start_sel_asserts

bind pss_start_sel pss_start_sel_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .start_i(start_i), .data_number_select_lines_i(data_number_select_lines_i),
  .direct_start_inputs_i(direct_start_inputs_i), .move_done_i(move_done_i),
  .non_positioning_op_i(non_positioning_op_i), .alarm_reset_i(alarm_reset_i),
  .input_a_i(input_a_i), .excitation_off_i(excitation_off_i),
  .position_preset_i(position_preset_i), .ready_o(ready_o), .move_start_o(move_start_o),
  .move_data_no_o(move_data_no_o), .torque_data_no_o(torque_data_no_o),
  .present_data_no_o(present_data_no_o), .seq_start_point_o(seq_start_point_o));

// >>> pss_host_model.sv
`timescale 1ns/1ps
// host controller on the discrete inputs, also standing in for the motion profile
module pss_host_model (
  input wire logic clk_i, // clock
  input wire logic ready_i, // driver ready
  output logic start_o, // select start
  output logic [3:0] lines_o, // entry select
  output logic [5:0] direct_o, // direct starts
  output logic step_o, // sequence step
  output logic done_o // move complete
);
  // everything low before the first request
  initial
  begin
    {start_o, lines_o, direct_o, step_o, done_o} <= '0;
  end
  // one move: k 0 select, 1 direct, 2 step; dly is profile length, bad steps while busy
  task run(input int k, input logic [3:0] v, input int dly, input bit bad);
    do @(posedge clk_i); while (ready_i !== 1'b1);
    if (k == 0)
    begin
      lines_o <= v;
      start_o <= 1'b1;
    end
    direct_o <= (k == 1) ? 6'h01 << v : 6'h00;
    step_o <= (k == 2);
    do @(posedge clk_i); while (ready_i !== 1'b0);
    {start_o, direct_o, step_o} <= '0;
    if (bad)
    begin
      @(posedge clk_i);
      step_o <= 1'b1;
      @(posedge clk_i);
      step_o <= 1'b0;
    end
    repeat (dly) @(posedge clk_i);
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    do @(posedge clk_i); while (ready_i !== 1'b1);
  endtask : run
endmodule : pss_host_model

// >>> testbench.sv
`timescale 1ns/1ps
// self-checking bench for the start selector
module testbench;
  import pss_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ready_o, move_start_o;
  logic start_i, sequence_step_input_i, move_done_i;
  logic [3:0] data_number_select_lines_i, move_data_no_o, torque_data_no_o, seq_start_point_o;
  logic [5:0] direct_start_inputs_i;
  logic [4:0] clr_q = 5'h00;
  logic [4:0] present_data_no_o;
  logic non_positioning_op_i, alarm_reset_i, input_a_i, excitation_off_i, position_preset_i;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  assign {non_positioning_op_i, alarm_reset_i, input_a_i, excitation_off_i,
    position_preset_i} = clr_q;
  pss_start_sel dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_i(start_i),
    .data_number_select_lines_i(data_number_select_lines_i),
    .direct_start_inputs_i(direct_start_inputs_i),
    .sequence_step_input_i(sequence_step_input_i), .move_done_i(move_done_i),
    .non_positioning_op_i(non_positioning_op_i), .alarm_reset_i(alarm_reset_i),
    .input_a_i(input_a_i), .excitation_off_i(excitation_off_i),
    .position_preset_i(position_preset_i), .ready_o(ready_o), .move_start_o(move_start_o),
    .move_data_no_o(move_data_no_o), .torque_data_no_o(torque_data_no_o),
    .present_data_no_o(present_data_no_o), .seq_start_point_o(seq_start_point_o));
  pss_host_model u_host (.clk_i(clk_i), .ready_i(ready_o), .start_o(start_i),
    .lines_o(data_number_select_lines_i), .direct_o(direct_start_inputs_i),
    .step_o(sequence_step_input_i), .done_o(move_done_i));
  always #2 clk_i = ~clk_i;
  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; pready is waited for, never assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task t_regs;
    apb(1'b0, OFS_DIRECT_MAP, 32'h0);
    chk(rd, 32'h00543210);
    apb(1'b0, OFS_SEQ_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[19:0], 20'h01F01);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
  endtask : t_regs
  task t_select;
    logic [3:0] tb [4];
    tb = '{4'h5, 4'hD, 4'hF, 4'h0};
    for (int i = 0; i < 4; i++)
    begin
      u_host.run(0, tb[i], 3 * i, i == 1);
      chk(move_data_no_o, tb[i]);
      // the stray step while busy would leave the same entry, so look at the method
      if (i == 1)
      begin
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[29:28], METHOD_SELECT);
        chk(rd[27:24], 4'hD);
      end
      chk(seq_start_point_o, tb[i]);
      chk(ready_o, 1'b1);
    end
  endtask : t_select
  // every clear source resets the start point and present number
  task t_clear;
    for (int b = 0; b < 5; b++)
    begin
      u_host.run(0, 4'h9, 1, 1'b0);
      clr_q[b] <= 1'b1;
      @(posedge clk_i);
      clr_q <= 5'h00;
      @(posedge clk_i);
      chk(seq_start_point_o, 4'h0);
      chk(present_data_no_o, 5'h1F);
    end
  endtask : t_clear
  // entries 1, 2, 4, 5 chained; 3 and 6 break the chain
  task t_seq;
    logic [3:0] ex [7];
    ex = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h4, 4'h5, 4'h3};
    // no entry here is a linked move, so no chained entry needs its flag forced on
    apb(1'b1, OFS_SEQ_FLAGS, 32'h0036);
    apb(1'b0, OFS_SEQ_FLAGS, 32'h0);
    chk(rd, 32'h0036);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 4)
        u_host.run(0, 4'h3, 1, 1'b1);
      u_host.run(2, 4'h0, i, 1'b0);
      chk(move_data_no_o, ex[i]);
    end
    chk(seq_start_point_o, 4'h3);
  endtask : t_seq
  // input i mapped to entry 15 - i
  task t_direct;
    apb(1'b1, OFS_DIRECT_MAP, 32'h00ABCDEF);
    apb(1'b0, OFS_DIRECT_MAP, 32'h0);
    chk(rd, 32'h00ABCDEF);
    for (int i = 0; i < 6; i++)
    begin
      u_host.run(1, i[3:0], 2, 1'b0);
      chk(move_data_no_o, 4'hF - i[3:0]);
      chk(seq_start_point_o, 4'hF - i[3:0]);
    end
    chk(torque_data_no_o, 4'h3);
    u_host.run(2, 4'h0, 0, 1'b0);
    chk(move_data_no_o, 4'hA);
  endtask : t_direct
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_select();
    t_clear();
    t_seq();
    t_direct();
    test_done();
  end
endmodule : testbench
